// ### tcs_assertions.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/100ps
module tcs_assertions #(
  parameter int SETTLE_CYCLES = tcs_pkg::SETTLE_CYC
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       cs_n_i,
  input wire logic       conv_start_o,
  input wire logic [4:0] conv_channel_o,
  input wire logic [1:0] conv_cycle_o,
  input wire logic       conv_done_i,
  input wire logic       interrupt_o,
  input wire logic       sleep_o,
  input wire logic       custom_table_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] gap;
  // Cycles since last finished cycle or idle
  always_ff @(posedge clk_i) begin
    if (rst_i || conv_done_i || interrupt_o) gap <= 16'h0000;
    else if (gap != 16'hffff) gap <= gap + 16'h0001;
  end
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_ack_lat; (cyc_i && stb_i && !$past(cyc_i && stb_i)) |-> ##2 ack_o; endproperty
  property p_busy; conv_start_o |-> !interrupt_o; endproperty
  property p_chan; conv_start_o |-> (conv_channel_o >= 5'h01 && conv_channel_o <= 5'h14); endproperty
  property p_cycle; conv_start_o |-> conv_cycle_o <= 2'h2; endproperty
  property p_settle; conv_start_o |-> gap >= SETTLE_CYCLES - 2; endproperty
  property p_startup; $fell(rst_i) |-> ##8 !interrupt_o; endproperty
  property p_sleep_cs; $rose(sleep_o) |-> $past(cs_n_i) && $past(cs_n_i, 2); endproperty
  property p_wake; $fell(sleep_o) |-> !$past(cs_n_i) || !$past(cs_n_i, 2) || !$past(cs_n_i, 3); endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_lat: assert property (p_ack_lat) else $error("ack latency wrong");
  a_busy: assert property (p_busy) else $error("conversion while ready");
  a_chan: assert property (p_chan) else $error("channel out of range");
  a_cycle: assert property (p_cycle) else $error("cycle index out of range");
  a_settle: assert property (p_settle) else $error("settle too short");
  a_startup: assert property (p_startup) else $error("start-up too short");
  a_sleep_cs: assert property (p_sleep_cs) else $error("sleep without cs rise");
  a_wake: assert property (p_wake) else $error("wake without cs low");
  c_conv: cover property (conv_start_o);
  c_sleep: cover property ($rose(sleep_o));
  c_custom: cover property (conv_start_o && custom_table_o);
endmodule

// ### tcs_byte_mem.sv
// Dual-port 1024 x 8 memory with registered read data
`timescale 1ns/100ps
module tcs_byte_mem (
  // Clock
  input wire logic clk_i,
  // Ports
  tcs_mem_if.mem   mp
);
  logic [7:0] store [0:1023];

  // Writes from both ports in one process; sequencer wins a clash
  always_ff @(posedge clk_i) begin
    if (mp.a_we) begin
      store[mp.a_addr] <= mp.a_wdata;
    end
    if (mp.b_we) begin
      store[mp.b_addr] <= mp.b_wdata;
    end
  end

  // Bus port read
  always_ff @(posedge clk_i) begin
    mp.a_rdata <= store[mp.a_addr];
  end

  // Sequencer port read
  always_ff @(posedge clk_i) begin
    mp.b_rdata <= store[mp.b_addr];
  end
endmodule

// ### tcs_fe_model.sv
// Front end model answering conversion cycle requests
`timescale 1ns/100ps
module tcs_fe_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Requests and bench controls
  input  wire logic        start_i,
  input  wire logic [4:0]  channel_i,
  input  wire logic [1:0]  cycle_i,
  input  wire logic        slow_i,
  input  wire logic        fault_i,
  // Answers
  output logic             done_o,
  output logic [31:0]      result_o,
  output logic             above_o,
  output logic             below_o
);
  logic [3:0]  cnt;
  logic [31:0] val;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      done_o <= 1'b0;
      val <= 32'h0;
    end else begin
      done_o <= (cnt == 4'h1);
      if (start_i) begin
        cnt <= slow_i ? 4'h9 : 4'h2;
        val <= {19'h0, channel_i, 6'h0, cycle_i};
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // fault lines valid only with done
  assign result_o = done_o ? val : ~val;
  assign above_o  = done_o ? fault_i : ~fault_i;
  assign below_o  = ~done_o;
endmodule

// ### tcs_mem_if.sv
// Two-port byte memory connection between sequencer and memory
`timescale 1ns/100ps
interface tcs_mem_if;
  logic [9:0] a_addr;
  logic       a_we;
  logic [7:0] a_wdata;
  logic [7:0] a_rdata;
  logic [9:0] b_addr;
  logic       b_we;
  logic [7:0] b_wdata;
  logic [7:0] b_rdata;
  modport mem  (input a_addr, a_we, a_wdata, b_addr, b_we, b_wdata, output a_rdata, b_rdata);
  modport user (output a_addr, a_we, a_wdata, b_addr, b_we, b_wdata, input a_rdata, b_rdata);
endinterface

// ### tcs_pkg.sv
// Shared constants for the temperature conversion sequencer
package tcs_pkg;
  // Register indexes; byte address on the bus is four times the index
  localparam logic [9:0] CMD_IDX       = 10'h000;
  localparam logic [9:0] CFG_IDX       = 10'h0f0;
  localparam logic [9:0] MASK_RSVD_IDX = 10'h0f4;
  localparam logic [9:0] MASK_HI_IDX   = 10'h0f5;
  localparam logic [9:0] MASK_MID_IDX  = 10'h0f6;
  localparam logic [9:0] MASK_LO_IDX   = 10'h0f7;
  localparam logic [9:0] DELAY_IDX     = 10'h0ff;
  // Memory areas
  localparam logic [9:0] RESULT_BASE   = 10'h010;
  localparam logic [9:0] ASSIGN_BASE   = 10'h200;
  localparam logic [9:0] TABLE_BASE    = 10'h250;
  localparam logic [9:0] TABLE_LAST    = 10'h3ca;
  // Command encodings and fields
  localparam logic [7:0] SLEEP_CMD     = 8'h97;
  localparam logic [4:0] CH_MULTI      = 5'h00;
  localparam logic [4:0] CH_MAX        = 5'h14;
  localparam logic [4:0] CH_MIN        = 5'h01;
  localparam int         START_BIT     = 7;
  localparam int         DONE_BIT      = 6;
  // Global configuration fields
  localparam int         FAHR_BIT      = 3;
  localparam logic [1:0] NOTCH_5060    = 2'h0;
  localparam logic [1:0] NOTCH_60      = 2'h1;
  localparam logic [1:0] NOTCH_50      = 2'h2;
  // Channel assignment fields (byte 0 type, bit 2 three-cycle flag)
  localparam logic [4:0] TYPE_NONE     = 5'h00;
  localparam logic [4:0] TYPE_CUSTOM   = 5'h09;
  localparam int         THREE_CYC_BIT = 2;
  // Result fault byte bits
  localparam int         SOFT_BIT      = 6;
  localparam int         HARD_BIT      = 7;
  // Reset values
  localparam logic [7:0] REG_RESET     = 8'h00;
  // Timing
  localparam int         CLK_NS        = 50;
  localparam int         SETTLE_NS     = 1000000;
  localparam int         UNIT_NS       = 100000;
  localparam int         SETTLE_CYC    = SETTLE_NS / CLK_NS;
  localparam int         UNIT_CYC      = UNIT_NS / CLK_NS;
  localparam int         STARTUP_CYC   = 16;
endpackage

// ### tcs_top.sv
// Conversion sequencer with Wishbone register slave and byte memory
//
// Operation
// - Command with channel 1..20 converts only that one channel.
// - Command with channel zero converts every channel set in the mask.
// - Masked run goes from highest channel number down to lowest.
// - Interrupt output low from run start until all conversions finish.
// - Masked channel without assignment data is skipped without converting.
// - Every result is stored in result memory, readable after the run.
// - Mask bits map one per channel over three locations, fourth reserved.
// - Command 0x97 arms sleep, entered at chip-select rising edge.
// - Sleep ends on chip select low or reset, then start-up runs.
// - Each result takes two or three conversion cycles.
// - Each conversion cycle waits a base settling delay first.
// - Extra settling adds delay byte times one hundred microseconds.
// - Global configuration selects filter notch, default 50/60 Hz.
// - Fahrenheit reported when configuration bit 3 set, else Celsius.
// - Sensor type 0b01001 uses the custom table instead of built-in curve.
// - Table entry k sits at base plus six times the sum of pointer and k.
// - Voltage above last table point flags soft fault, extrapolates.
// - Voltage below first operating point flags soft fault, extrapolates.
// - Table voltages are signed 24-bit millivolts, 14 fraction bits.
// - Table temperatures are unsigned 24-bit Kelvin, 10 fraction bits.
// - Assignment holds table pointer offset and entry count minus one.
`timescale 1ns/100ps
module tcs_top #(
  parameter int SETTLE_CYCLES = tcs_pkg::SETTLE_CYC,
  parameter int UNIT_CYCLES   = tcs_pkg::UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Serial port chip select pin
  input  wire logic        cs_n_i,
  // Front end conversion handshake
  output logic             conv_start_o,
  output logic [4:0]       conv_channel_o,
  output logic [1:0]       conv_cycle_o,
  input  wire logic        conv_done_i,
  input  wire logic [31:0] conv_result_i,
  input  wire logic        above_last_i,
  input  wire logic        below_first_i,
  // Configuration and status
  output logic             interrupt_o,
  output logic             sleep_o,
  output logic [1:0]       notch_sel_o,
  output logic             fahrenheit_o,
  output logic             custom_table_o,
  output logic [9:0]       table_base_o,
  output logic [5:0]       table_len_o
);
  typedef enum logic [9:0] {
    S_START  = 10'h001,
    S_IDLE   = 10'h002,
    S_SCAN   = 10'h004,
    S_FETCH  = 10'h008,
    S_CHECK  = 10'h010,
    S_SETTLE = 10'h020,
    S_CONV   = 10'h040,
    S_STORE  = 10'h080,
    S_NEXT   = 10'h100,
    S_SLEEP  = 10'h200
  } tcs_state_t;

  tcs_mem_if  mif ();
  tcs_state_t state;
  tcs_state_t next_state;

  logic [7:0]  cmd;
  logic [7:0]  cfg;
  logic [7:0]  mask_hi;
  logic [7:0]  mask_mid;
  logic [7:0]  mask_lo;
  logic [7:0]  delay;
  logic        pend;
  logic        sleep_arm;
  logic        cs_q1;
  logic        cs_q2;
  logic        cs_q3;
  logic        go;
  logic [4:0]  go_ch;
  logic        multi;
  logic [4:0]  ch;
  logic [2:0]  idx;
  logic [1:0]  ncyc;
  logic [1:0]  cyc_idx;
  logic [15:0] cnt;
  logic [7:0]  ext;
  logic [7:0]  asg [0:3];
  logic [31:0] result;
  logic [19:0] mask_vec;
  logic [9:0]  bus_idx;
  logic        bus_hit;
  logic        bus_wr;
  logic        cmd_wr;
  logic        cs_rise;
  logic        cs_low;
  logic [9:0]  chan_off;
  logic [10:0] table_end;

  tcs_byte_mem tcs_byte_mem_i (
    .clk_i (clk_i),
    .mp    (mif.mem)
  );

  // Bus decode
  assign bus_idx = adr_i[11:2];
  assign bus_hit = (adr_i[31:12] == 20'h00000);
  assign bus_wr  = cyc_i & stb_i & we_i & sel_i[0] & ~pend & ~ack_o & bus_hit;
  assign cmd_wr  = bus_wr & (bus_idx == tcs_pkg::CMD_IDX);
  assign mif.a_addr  = bus_idx;
  assign mif.a_we    = bus_wr;
  assign mif.a_wdata = dat_i[7:0];

  // Two-cycle Wishbone answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend  <= 1'b0;
      ack_o <= 1'b0;
    end else begin
      pend  <= cyc_i & stb_i & ~pend & ~ack_o;
      ack_o <= pend & cyc_i & stb_i;
    end
  end

  // Read data mux, registers first, then memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (pend) begin
      dat_o <= 32'h00000000;
      if (bus_hit) begin
        unique case (bus_idx)
          tcs_pkg::CMD_IDX:       dat_o[7:0] <= cmd;
          tcs_pkg::CFG_IDX:       dat_o[7:0] <= cfg;
          tcs_pkg::MASK_RSVD_IDX: dat_o[7:0] <= 8'h00;
          tcs_pkg::MASK_HI_IDX:   dat_o[7:0] <= mask_hi;
          tcs_pkg::MASK_MID_IDX:  dat_o[7:0] <= mask_mid;
          tcs_pkg::MASK_LO_IDX:   dat_o[7:0] <= mask_lo;
          tcs_pkg::DELAY_IDX:     dat_o[7:0] <= delay;
          default:                dat_o[7:0] <= mif.a_rdata;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg      <= tcs_pkg::REG_RESET;
      mask_hi  <= tcs_pkg::REG_RESET;
      mask_mid <= tcs_pkg::REG_RESET;
      mask_lo  <= tcs_pkg::REG_RESET;
      delay    <= tcs_pkg::REG_RESET;
    end else if (bus_wr) begin
      if (bus_idx == tcs_pkg::CFG_IDX) begin
        cfg <= dat_i[7:0];
      end
      if (bus_idx == tcs_pkg::MASK_HI_IDX) begin
        mask_hi <= dat_i[7:0];
      end
      if (bus_idx == tcs_pkg::MASK_MID_IDX) begin
        mask_mid <= dat_i[7:0];
      end
      if (bus_idx == tcs_pkg::MASK_LO_IDX) begin
        mask_lo <= dat_i[7:0];
      end
      if (bus_idx == tcs_pkg::DELAY_IDX) begin
        delay <= dat_i[7:0];
      end
    end
  end

  assign mask_vec = {mask_hi[3:0], mask_mid, mask_lo};

  assign notch_sel_o  = cfg[1:0];
  assign fahrenheit_o = cfg[tcs_pkg::FAHR_BIT];

  // Command register; completion status wins over a host write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd <= tcs_pkg::REG_RESET;
    end else if (state == S_NEXT && !(multi && ch != tcs_pkg::CH_MIN)) begin
      cmd <= {2'b01, 1'b0, go_ch};
    end else if (cmd_wr) begin
      cmd <= dat_i[7:0];
    end
  end

  // Start request taken only in idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go    <= 1'b0;
      go_ch <= 5'h00;
    end else begin
      go <= cmd_wr & dat_i[tcs_pkg::START_BIT] & (state == S_IDLE) & (dat_i[4:0] <= tcs_pkg::CH_MAX);
      if (cmd_wr && state == S_IDLE) begin
        go_ch <= dat_i[4:0];
      end
    end
  end

  // Chip select synchroniser and edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
    end else begin
      cs_q1 <= cs_n_i;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
    end
  end
  assign cs_rise = cs_q2 & ~cs_q3;
  assign cs_low  = ~cs_q2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_arm <= 1'b0;
    end else if (cmd_wr && state == S_IDLE) begin
      sleep_arm <= (dat_i[7:0] == tcs_pkg::SLEEP_CMD);
    end else if (state != S_IDLE) begin
      sleep_arm <= 1'b0;
    end
  end

  // State sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      S_START:  if (cnt == 16'h0000) next_state = S_IDLE;
      S_IDLE: begin
        if (sleep_arm && cs_rise) begin
          next_state = S_SLEEP;
        end else if (go) begin
          next_state = (go_ch == tcs_pkg::CH_MULTI) ? S_SCAN : S_FETCH;
        end
      end
      S_SCAN: begin
        if (mask_vec[ch - 5'h01]) begin
          next_state = S_FETCH;
        end else if (ch == tcs_pkg::CH_MIN) begin
          next_state = S_NEXT;
        end
      end
      S_FETCH:  if (idx == 3'h4) next_state = S_CHECK;
      S_CHECK:  next_state = (asg[0][7:3] == tcs_pkg::TYPE_NONE) ? S_NEXT : S_SETTLE;
      S_SETTLE: if (cnt == 16'h0000 && ext == 8'h00) next_state = S_CONV;
      S_CONV: begin
        if (conv_done_i) begin
          next_state = (cyc_idx == ncyc - 2'h1) ? S_STORE : S_SETTLE;
        end
      end
      S_STORE:  if (idx == 3'h3) next_state = S_NEXT;
      S_NEXT:   next_state = (multi && ch != tcs_pkg::CH_MIN) ? S_SCAN : S_IDLE;
      S_SLEEP:  if (cs_low) next_state = S_START;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_START;
    end else begin
      state <= next_state;
    end
  end

  // Channel pointer and run kind
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch    <= 5'h00;
      multi <= 1'b0;
    end else if (state == S_IDLE && go) begin
      multi <= (go_ch == tcs_pkg::CH_MULTI);
      ch    <= (go_ch == tcs_pkg::CH_MULTI) ? tcs_pkg::CH_MAX : go_ch;
    end else if (state == S_SCAN && !mask_vec[ch - 5'h01] && ch != tcs_pkg::CH_MIN) begin
      ch <= ch - 5'h01;
    end else if (state == S_NEXT && multi && ch != tcs_pkg::CH_MIN) begin
      ch <= ch - 5'h01;
    end
  end

  // Byte index for fetch and store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx <= 3'h0;
    end else if (state == S_FETCH || state == S_STORE) begin
      idx <= (next_state == state) ? idx + 3'h1 : 3'h0;
    end else begin
      idx <= 3'h0;
    end
  end

  // Assignment bytes captured one cycle after each read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        asg[i] <= 8'h00;
      end
    end else if (state == S_FETCH && idx != 3'h0) begin
      asg[idx[1:0] - 2'h1] <= mif.b_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ncyc    <= 2'h2;
      cyc_idx <= 2'h0;
    end else if (state == S_CHECK) begin
      ncyc    <= asg[0][tcs_pkg::THREE_CYC_BIT] ? 2'h3 : 2'h2;
      cyc_idx <= 2'h0;
    end else if (state == S_CONV && conv_done_i) begin
      cyc_idx <= cyc_idx + 2'h1;
    end
  end

  // Settling and start-up counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 16'(tcs_pkg::STARTUP_CYC - 1);
      ext <= 8'h00;
    end else if (next_state == S_START && state != S_START) begin
      cnt <= 16'(tcs_pkg::STARTUP_CYC - 1);
    end else if (next_state == S_SETTLE && state != S_SETTLE) begin
      cnt <= 16'(SETTLE_CYCLES - 1);
      ext <= delay;
    end else if (state == S_SETTLE && cnt == 16'h0000 && ext != 8'h00) begin
      cnt <= 16'(UNIT_CYCLES - 1);
      ext <= ext - 8'h01;
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end
  end

  // Front end requests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_start_o   <= 1'b0;
      conv_channel_o <= 5'h00;
      conv_cycle_o   <= 2'h0;
    end else begin
      conv_start_o <= (state == S_SETTLE) && (next_state == S_CONV);
      if (state == S_SETTLE) begin
        conv_channel_o <= ch;
        conv_cycle_o   <= cyc_idx;
      end
    end
  end

  assign table_end = 11'(tcs_pkg::TABLE_BASE) + 11'(6) * (11'(asg[2][5:0]) + 11'(asg[3][5:0]) + 11'h001)
                     - 11'h001;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      custom_table_o <= 1'b0;
      table_base_o   <= 10'h000;
      table_len_o    <= 6'h00;
    end else if (state == S_CHECK) begin
      custom_table_o <= (asg[0][7:3] == tcs_pkg::TYPE_CUSTOM);
      table_base_o   <= 10'(tcs_pkg::TABLE_BASE + 10'(6) * 10'(asg[2][5:0]));
      table_len_o    <= asg[3][5:0];
    end
  end

  // Result capture with fault flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= 32'h00000000;
    end else if (state == S_CONV && conv_done_i) begin
      result <= conv_result_i;
      if (custom_table_o) begin
        result[24 + tcs_pkg::SOFT_BIT] <= conv_result_i[24 + tcs_pkg::SOFT_BIT] | above_last_i | below_first_i;
        result[24 + tcs_pkg::HARD_BIT] <= conv_result_i[24 + tcs_pkg::HARD_BIT]
                                          | (table_end > 11'(tcs_pkg::TABLE_LAST));
      end
    end
  end

  // Sequencer memory port
  assign chan_off = {3'h0, ch - 5'h01, 2'h0};
  always_comb begin
    mif.b_addr  = tcs_pkg::ASSIGN_BASE + chan_off + {7'h00, idx};
    mif.b_we    = 1'b0;
    mif.b_wdata = 8'h00;
    if (state == S_STORE) begin
      mif.b_addr  = tcs_pkg::RESULT_BASE + chan_off + {7'h00, idx};
      mif.b_we    = 1'b1;
      mif.b_wdata = result[31 - 8 * idx[1:0] -: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_o <= 1'b0;
      sleep_o     <= 1'b0;
    end else begin
      interrupt_o <= (next_state == S_IDLE) || (next_state == S_SLEEP);
      sleep_o     <= (next_state == S_SLEEP);
    end
  end
endmodule

// ### tcs_top_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tcs_top_tb;
  localparam int SET = 20;
  localparam int UNT = 5;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [31:0] adr_i = 32'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        cs_n_i = 1'b1;
  logic        slow = 1'b0;
  logic        fault = 1'b0;
  logic [31:0] dat_o, conv_result_i;
  logic        ack_o, conv_start_o, conv_done_i, above_last_i, below_first_i;
  logic        interrupt_o, sleep_o, fahrenheit_o, custom_table_o;
  logic [4:0]  conv_channel_o;
  logic [1:0]  conv_cycle_o, notch_sel_o;
  logic [9:0]  table_base_o, tb_base;
  logic [5:0]  table_len_o, tb_len;
  logic [7:0]  q;
  logic [4:0]  chq[$];
  logic [1:0]  cyq[$];
  int          n_errors = 0, cmp_count = 0, cycles = 0, gap = 0, lgap = 0;
  // Clock
  always #25 clk_i = ~clk_i;
  tcs_top #(.SETTLE_CYCLES(SET), .UNIT_CYCLES(UNT)) tcs_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cs_n_i(cs_n_i), .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .conv_cycle_o(conv_cycle_o),
    .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .above_last_i(above_last_i),
    .below_first_i(below_first_i), .interrupt_o(interrupt_o), .sleep_o(sleep_o), .notch_sel_o(notch_sel_o),
    .fahrenheit_o(fahrenheit_o), .custom_table_o(custom_table_o), .table_base_o(table_base_o),
    .table_len_o(table_len_o));
  tcs_fe_model tcs_fe_model_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o), .channel_i(conv_channel_o),
    .cycle_i(conv_cycle_o), .slow_i(slow), .fault_i(fault), .done_o(conv_done_i), .result_o(conv_result_i),
    .above_o(above_last_i), .below_o(below_first_i));
  // Log starts, settle gaps and table fields; timeout
  always @(posedge clk_i) begin
    gap = (conv_done_i === 1'b1) ? 0 : gap + 1;
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      final_report();
    end
    if (conv_start_o === 1'b1) begin
      chq.push_back(conv_channel_o);
      cyq.push_back(conv_cycle_o);
      lgap = gap;
      if (custom_table_o === 1'b1) begin
        tb_base = table_base_o;
        tb_len = table_len_o;
      end
    end
  end
  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Classic Wishbone single cycle
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, {20'h0, ix, 2'b00}, d, r);
  endtask
  task automatic rd(input logic [9:0] ix, output logic [7:0] r);
    wb(1'b0, {20'h0, ix, 2'b00}, 8'h00, r);
  endtask
  task automatic wait_on(input bit s, input logic lvl);
    int n;
    n = 0;
    while (((s ? sleep_o : interrupt_o) !== lvl) && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk(n < 3000, 1'b1, "wait level");
  endtask
  task automatic t_reset();
    @(negedge clk_i);
    chk(interrupt_o, 1'b0, "start-up busy");
    wait_on(1'b0, 1'b1);
    rd(tcs_pkg::CFG_IDX, q);
    chk(q, tcs_pkg::REG_RESET, "cfg reset");
    chk({notch_sel_o, fahrenheit_o}, {tcs_pkg::NOTCH_5060, 1'b0}, "default notch, units");
    $display("test reset done");
  endtask
  task automatic t_cfg();
    logic [7:0] v[3] = '{8'h01, 8'h02, 8'h08};
    logic [2:0] e[3] = '{{tcs_pkg::NOTCH_60, 1'b0}, {tcs_pkg::NOTCH_50, 1'b0}, {tcs_pkg::NOTCH_5060, 1'b1}};
    for (int i = 0; i < 3; i++) begin
      wr(tcs_pkg::CFG_IDX, v[i]);
      rd(tcs_pkg::CFG_IDX, q);
      chk({q, notch_sel_o, fahrenheit_o}, {v[i], e[i]}, "cfg field");
    end
    wb(1'b1, 32'h0000_1000, 8'h5a, q);
    wb(1'b0, 32'h0000_1000, 8'h00, q);
    chk(q, 8'h00, "unmapped read");
    $display("test cfg done");
  endtask
  task automatic t_single();
    logic [7:0] e[4] = '{8'h00, 8'h00, 8'h05, 8'h01};
    wr(tcs_pkg::ASSIGN_BASE + 10'h010, 8'h10);
    wr(tcs_pkg::MASK_LO_IDX, 8'hff);
    wr(tcs_pkg::DELAY_IDX, 8'h02);
    chq.delete();
    cyq.delete();
    wr(tcs_pkg::CMD_IDX, 8'h85);
    wait_on(1'b0, 1'b0);
    wait_on(1'b0, 1'b1);
    chk({chq.size() == 2, chq[0], chq[1], cyq[0], cyq[1]}, {1'b1, 14'ha51}, "single starts");
    chk(lgap >= SET + 2 * UNT && lgap <= SET + 2 * UNT + 4, 1'b1, "settle delay");
    rd(tcs_pkg::CMD_IDX, q);
    chk(q, 8'h45, "done status");
    for (int i = 0; i < 4; i++) begin
      rd(tcs_pkg::RESULT_BASE + 10'h010 + 10'(i), q);
      chk(q, e[i], "single result");
    end
    $display("test single done");
  endtask
  task automatic t_masked();
    logic [4:0] ech[7] = '{5'h14, 5'h14, 5'h14, 5'h13, 5'h13, 5'h01, 5'h01};
    logic [1:0] ecy[7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
    wr(tcs_pkg::ASSIGN_BASE + 10'h04c, 8'h4c);
    wr(tcs_pkg::ASSIGN_BASE + 10'h04e, 8'h02);
    wr(tcs_pkg::ASSIGN_BASE + 10'h04f, 8'h09);
    wr(tcs_pkg::ASSIGN_BASE + 10'h048, 8'h10);
    wr(tcs_pkg::ASSIGN_BASE + 10'h03c, 8'h00);
    wr(tcs_pkg::ASSIGN_BASE, 8'h10);
    for (int k = 0; k < 60; k++) begin
      wr(tcs_pkg::TABLE_BASE + 10'd12 + 10'(k), (k % 3 == 1) ? 8'(k / 6) : 8'h00);
    end
    wr(tcs_pkg::MASK_RSVD_IDX, 8'hff);
    wr(tcs_pkg::MASK_HI_IDX, 8'hfc);
    wr(tcs_pkg::MASK_MID_IDX, 8'h80);
    wr(tcs_pkg::MASK_LO_IDX, 8'h01);
    wr(tcs_pkg::DELAY_IDX, 8'h00);
    slow <= 1'b1;
    fault <= 1'b1;
    chq.delete();
    cyq.delete();
    wr(tcs_pkg::CMD_IDX, 8'h80);
    wait_on(1'b0, 1'b0);
    wait_on(1'b0, 1'b1);
    @(posedge clk_i);
    slow <= 1'b0;
    fault <= 1'b0;
    chk(chq.size(), 7, "masked count");
    for (int i = 0; i < 7; i++) chk({chq[i], cyq[i]}, {ech[i], ecy[i]}, "masked order");
    chk({tb_base, tb_len}, {tcs_pkg::TABLE_BASE + 10'd12, 6'd9}, "table fields");
    rd(tcs_pkg::RESULT_BASE + 10'h04c, q);
    chk(q, 8'h40, "custom soft fault");
    rd(tcs_pkg::RESULT_BASE + 10'h048, q);
    chk(q, 8'h00, "standard no fault");
    rd(tcs_pkg::RESULT_BASE + 10'h002, q);
    chk(q, 8'h01, "lowest result");
    wr(tcs_pkg::ASSIGN_BASE + 10'h04e, 8'h3f);
    wr(tcs_pkg::CMD_IDX, 8'h94);
    wait_on(1'b0, 1'b0);
    wait_on(1'b0, 1'b1);
    rd(tcs_pkg::RESULT_BASE + 10'h04c, q);
    chk(q, 8'h80, "table end past limit");
    $display("test masked done");
  endtask
  task automatic t_sleep();
    cs_n_i <= 1'b0;
    wr(tcs_pkg::CMD_IDX, tcs_pkg::SLEEP_CMD);
    repeat (4) @(negedge clk_i);
    chk(sleep_o, 1'b0, "awake before cs rise");
    @(posedge clk_i);
    cs_n_i <= 1'b1;
    wait_on(1'b1, 1'b1);
    repeat (20) @(negedge clk_i);
    chk(sleep_o, 1'b1, "stays asleep");
    @(posedge clk_i);
    cs_n_i <= 1'b0;
    wait_on(1'b1, 1'b0);
    wait_on(1'b0, 1'b1);
    $display("test sleep done");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_cfg();
    t_single();
    t_masked();
    t_sleep();
    final_report();
  end
endmodule
bind tcs_top tcs_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) tcs_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .cs_n_i(cs_n_i), .conv_start_o(conv_start_o),
  .conv_channel_o(conv_channel_o), .conv_cycle_o(conv_cycle_o), .conv_done_i(conv_done_i),
  .interrupt_o(interrupt_o), .sleep_o(sleep_o), .custom_table_o(custom_table_o));
